/* File: logic/pin_input_sync.sv */
// three-stage pin synchroniser with agreement filter and transition capture
`timescale 1ns/100ps
module pin_input_sync (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // pad side
   input  wire logic padIn,
   input  wire logic digitalMode,
   // synchronised results
   output logic      level,
   output logic      riseEvt,
   output logic      fallEvt
);
   logic s1_r, s2_r, s3_r, level_r;
   logic rise_r, fall_r;
   wire  agree   = (s2_r == s3_r);
   wire  changed = agree && (s3_r != level_r);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s1_r    <= xbar_pkg::IN_IDLE;
         s2_r    <= xbar_pkg::IN_IDLE;
         s3_r    <= xbar_pkg::IN_IDLE;
         level_r <= xbar_pkg::IN_IDLE;
         rise_r  <= 1'b0;
         fall_r  <= 1'b0;
      end else begin
         s1_r    <= padIn;
         s2_r    <= s1_r;
         s3_r    <= s2_r;
         if (changed) begin
            level_r <= s3_r;
         end
         // analog pins never report transitions
         rise_r  <= changed && s3_r && digitalMode;
         fall_r  <= changed && !s3_r && digitalMode;
      end
   end

   assign level   = level_r;
   assign riseEvt = rise_r;
   assign fallEvt = fall_r;
endmodule : pin_input_sync

/* File: logic/priority_crossbar_pin_assign.sv */
// priority crossbar: places enabled peripheral signals on port pins and captures pin events
`timescale 1ns/100ps
module priority_crossbar_pin_assign (
   // clock and reset
   input  wire logic                          clk,
   input  wire logic                          rst,
   // configuration
   input  wire xbar_pkg::xbar_cfg_type        crossbarConfig,
   input  wire logic [15:0]                   pin_skip_mask,
   input  wire logic [1:0]                    slave_select_mode_field,
   input  wire logic [15:0]                   pinDigitalMode,
   // peripheral side
   input  wire xbar_pkg::periph_out_type      periphOut,
   output logic [xbar_pkg::NUM_SIG-1:0]       periphIn,
   output logic [xbar_pkg::NUM_SIG-1:0]       sigAssigned,
   // general purpose port side
   input  wire logic [15:0]                   gpioOut,
   input  wire logic [15:0]                   gpioOe,
   output logic [15:0]                        gpioIn,
   // pads
   input  wire logic [15:0]                   padIn,
   output logic [15:0]                        padOut,
   output logic [15:0]                        padOe,
   // event capture
   output logic [15:0]                        pinRiseEvt,
   output logic [15:0]                        pinFallEvt,
   output logic                               eventWake
);
   import xbar_pkg::*;

   // enable decode from the three configuration registers
   wire                xbarOn    = crossbarConfig.config2[CFG2_XBAR_EN];
   wire [7:0]          cfg0      = crossbarConfig.config0;
   wire [7:0]          cfg1      = crossbarConfig.config1;
   wire [2:0]          captCount = cfg1[CFG1_CAPT_LSB +: 3];
   wire                serialOn  = xbarOn && cfg0[CFG0_SERIAL_EN];
   wire                spiOn     = xbarOn && cfg0[CFG0_SPI_EN];
   wire                smbOn     = xbarOn && cfg0[CFG0_SMB_EN];
   // any nonzero mode value selects four-wire operation
   wire                fourWire  = (slave_select_mode_field != 2'h0);
   wire  [NUM_SIG-1:0] want;

   assign want[SIG_SERIAL_TX]  = serialOn;
   assign want[SIG_SERIAL_RX]  = serialOn;
   assign want[SIG_SPI_CLK]    = spiOn;
   assign want[SIG_SPI_IN]     = spiOn;
   assign want[SIG_SPI_OUT]    = spiOn;
   assign want[SIG_SPI_SELECT] = spiOn && fourWire;
   assign want[SIG_SMB_DATA]   = smbOn;
   assign want[SIG_SMB_CLOCK]  = smbOn;
   assign want[SIG_COMP_SYNC]  = xbarOn && cfg0[CFG0_CMP_EN];
   assign want[SIG_COMP_ASYNC] = xbarOn && cfg0[CFG0_CMPA_EN];
   assign want[SIG_CLOCK_OUT]  = xbarOn && cfg0[CFG0_CLKOUT_EN];
   assign want[SIG_COUNTER_IN] = xbarOn && cfg1[CFG1_CNTIN_EN];
   assign want[SIG_TIMER0]     = xbarOn && cfg1[CFG1_T0_EN];
   assign want[SIG_TIMER1]     = xbarOn && cfg1[CFG1_T1_EN];

   // capture channels are enabled as a count from channel 0 upward
   genvar gc;
   generate
      for (gc = 0; gc < 3; gc++) begin : g_capt
         assign want[SIG_CAPTURE0 + gc] = xbarOn && (captCount > 3'(gc));
      end
   endgenerate

   // combinational placement in priority order
   logic [3:0]         sigPinNxt [NUM_SIG];
   logic [NUM_SIG-1:0] sigValidNxt;
   logic [15:0]        occupied;
   logic               found;

   always_comb begin
      occupied    = pin_skip_mask;
      sigValidNxt = '0;
      found       = 1'b0;
      for (int s = 0; s < NUM_SIG; s++) begin
         sigPinNxt[s] = 4'h0;
      end
      // serial pair sits on its fixed pins whatever the skip bits say
      if (serialOn) begin
         sigPinNxt[SIG_SERIAL_TX]   = SERIAL_TX_PIN;
         sigPinNxt[SIG_SERIAL_RX]   = SERIAL_RX_PIN;
         sigValidNxt[SIG_SERIAL_TX] = 1'b1;
         sigValidNxt[SIG_SERIAL_RX] = 1'b1;
         occupied[SERIAL_TX_PIN]    = 1'b1;
         occupied[SERIAL_RX_PIN]    = 1'b1;
      end
      // signals after the serial pair, highest priority first
      for (int s = SIG_SPI_CLK; s < NUM_SIG; s++) begin
         found = 1'b0;
         if (want[s]) begin
            // first free pin from the bottom up
            for (int p = 0; p < NUM_PINS; p++) begin
               if (!found && !occupied[p]) begin
                  found        = 1'b1;
                  sigPinNxt[s] = 4'(p);
                  occupied[p]  = 1'b1;
               end
            end
         end
         sigValidNxt[s] = found;
      end
   end

   // placement takes effect one clock after any configuration change
   logic [3:0]         sigPin_r [NUM_SIG];
   logic [NUM_SIG-1:0] sigValid_r;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sigValid_r <= '0;
         for (int s = 0; s < NUM_SIG; s++) begin
            sigPin_r[s] <= 4'h0;
         end
      end else begin
         sigValid_r <= sigValidNxt;
         for (int s = 0; s < NUM_SIG; s++) begin
            sigPin_r[s] <= sigPinNxt[s];
         end
      end
   end

   // input synchronisers and transition capture on every pin
   logic [15:0] pinLevel;

   // every pin gets a synchroniser, skipped or routed alike
   genvar gp;
   generate
      for (gp = 0; gp < NUM_PINS; gp++) begin : g_pin
         pin_input_sync u_sync (
            .clk         (clk),
            .rst         (rst),
            .padIn       (padIn[gp]),
            .digitalMode (pinDigitalMode[gp]),
            .level       (pinLevel[gp]),
            .riseEvt     (pinRiseEvt[gp]),
            .fallEvt     (pinFallEvt[gp])
         );
      end
   endgenerate

   assign eventWake = |(pinRiseEvt | pinFallEvt);

   // owner lookup per pin from the registered placement
   // placement never puts two signals on one pin, so at most one match per pin
   logic [15:0] ownVal;
   logic [15:0] ownDrv;
   logic [15:0] owned;

   always_comb begin
      owned  = '0;
      ownVal = '0;
      ownDrv = '0;
      for (int p = 0; p < NUM_PINS; p++) begin
         for (int s = 0; s < NUM_SIG; s++) begin
            if (sigValid_r[s] && (sigPin_r[s] == 4'(p))) begin
               owned[p]  = 1'b1;
               ownVal[p] = periphOut.value[s];
               ownDrv[p] = periphOut.drive[s];
            end
         end
      end
   end

   // unowned pins fall back to ordinary port I/O
   wire [15:0] padOutNxt = (owned & ownVal) | (~owned & gpioOut);
   wire [15:0] padOeNxt  = (owned & ownDrv) | (~owned & gpioOe);
   wire [15:0] gpioInNxt = pinLevel & pinDigitalMode;

   // a signal with no pin reads the idle level
   wire  [NUM_SIG-1:0] periphInNxt;

   generate
      for (gc = 0; gc < NUM_SIG; gc++) begin : g_sigin
         assign periphInNxt[gc] = sigValid_r[gc] ? pinLevel[sigPin_r[gc]] : IN_IDLE;
      end
   endgenerate

   // pad, port and peripheral inputs all leave through registers
   logic [15:0]        padOut_r;
   logic [15:0]        padOe_r;
   logic [15:0]        gpioIn_r;
   logic [NUM_SIG-1:0] periphIn_r;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         padOut_r   <= '1;
         padOe_r    <= '0;
         gpioIn_r   <= '0;
         periphIn_r <= '1;
      end else begin
         padOut_r   <= padOutNxt;
         padOe_r    <= padOeNxt;
         gpioIn_r   <= gpioInNxt;
         periphIn_r <= periphInNxt;
      end
   end

   // ports come straight from their registers
   assign padOut      = padOut_r;
   assign padOe       = padOe_r;
   assign gpioIn      = gpioIn_r;
   assign periphIn    = periphIn_r;
   assign sigAssigned = sigValid_r;
endmodule : priority_crossbar_pin_assign

/* File: logic/xbar_pkg.sv */
// shared constants and carrier types for the priority crossbar pin assigner
package xbar_pkg;
   localparam int NUM_PINS = 16;
   localparam int NUM_SIG  = 17;

   // signal indices in priority order, serial pair first
   localparam logic [4:0] SIG_SERIAL_TX   = 5'h00;
   localparam logic [4:0] SIG_SERIAL_RX   = 5'h01;
   localparam logic [4:0] SIG_SPI_CLK     = 5'h02;
   localparam logic [4:0] SIG_SPI_IN      = 5'h03;
   localparam logic [4:0] SIG_SPI_OUT     = 5'h04;
   localparam logic [4:0] SIG_SPI_SELECT  = 5'h05;
   localparam logic [4:0] SIG_SMB_DATA    = 5'h06;
   localparam logic [4:0] SIG_SMB_CLOCK   = 5'h07;
   localparam logic [4:0] SIG_COMP_SYNC   = 5'h08;
   localparam logic [4:0] SIG_COMP_ASYNC  = 5'h09;
   localparam logic [4:0] SIG_CLOCK_OUT   = 5'h0A;
   localparam logic [4:0] SIG_CAPTURE0    = 5'h0B;
   localparam logic [4:0] SIG_COUNTER_IN  = 5'h0E;
   localparam logic [4:0] SIG_TIMER0      = 5'h0F;
   localparam logic [4:0] SIG_TIMER1      = 5'h10;

   // fixed serial pins
   localparam logic [3:0] SERIAL_TX_PIN = 4'h4;
   localparam logic [3:0] SERIAL_RX_PIN = 4'h5;

   // crossbar_config_0 field positions
   localparam int CFG0_SERIAL_EN = 0;
   localparam int CFG0_SPI_EN    = 1;
   localparam int CFG0_SMB_EN    = 2;
   localparam int CFG0_CMP_EN    = 3;
   localparam int CFG0_CMPA_EN   = 4;
   localparam int CFG0_CLKOUT_EN = 5;
   // crossbar_config_1 field positions
   localparam int CFG1_CAPT_LSB  = 0;
   localparam int CFG1_CNTIN_EN  = 3;
   localparam int CFG1_T0_EN     = 4;
   localparam int CFG1_T1_EN     = 5;
   // crossbar_config_2 field positions
   localparam int CFG2_XBAR_EN   = 6;

   localparam logic [7:0]  CFG_RESET  = 8'h00;
   localparam logic [15:0] SKIP_RESET = 16'h0000;
   localparam logic        IN_IDLE    = 1'b1;

   typedef struct packed {
      logic [7:0] config2;
      logic [7:0] config1;
      logic [7:0] config0;
   } xbar_cfg_type;

   typedef struct packed {
      logic [NUM_SIG-1:0] value;
      logic [NUM_SIG-1:0] drive;
   } periph_out_type;
endpackage : xbar_pkg

/* File: sim/pad_model.sv */
// pad-side model: crossbar pad driver, external source and weak pull-up
`timescale 1ns/100ps
module pad_model (
   // crossbar pad outputs
   input  logic [15:0] padOut,
   input  logic [15:0] padOe,
   // external source from the bench
   input  logic [15:0] extOe,
   input  logic [15:0] extVal,
   // level at the pad receivers
   output logic [15:0] padIn
);
   // an undriven pad floats up through the weak pull-up
   assign padIn = (padOe & padOut) | (~padOe & (~extOe | extVal));
endmodule : pad_model

/* File: sim/priority_crossbar_pin_assign_asserts.sv */
// assertion checker for the priority crossbar pin assigner
`timescale 1ns/100ps
module priority_crossbar_pin_assign_asserts (
   // clock and reset
   input logic                             clk,
   input logic                             rst,
   // configuration and peripheral side
   input xbar_pkg::xbar_cfg_type           crossbarConfig,
   input logic [15:0]                      pin_skip_mask,
   input logic [1:0]                       slave_select_mode_field,
   input logic [15:0]                      pinDigitalMode,
   input xbar_pkg::periph_out_type         periphOut,
   input logic [xbar_pkg::NUM_SIG-1:0]     sigAssigned,
   input logic [15:0]                      gpioOe,
   // pads and events
   input logic [15:0]                      padOut,
   input logic [15:0]                      padOe,
   input logic [15:0]                      pinRiseEvt,
   input logic [15:0]                      pinFallEvt,
   input logic                             eventWake
);
   import xbar_pkg::*;
   default clocking @(posedge clk);
   endclocking
   default disable iff (rst);
   property p_serial_pins;
      $past(sigAssigned[0]) |-> padOut[4] == $past(periphOut.value[0]) && padOe[4] == $past(periphOut.drive[0]);
   endproperty
   a_serial_pins: assert property (p_serial_pins) else $error("serial tx pin wrong");
   property p_serial_pair;
      !$past(rst) |-> sigAssigned[1:0] == {2{$past(crossbarConfig.config0[0]) & $past(crossbarConfig.config2[6])}};
   endproperty
   a_serial_pair: assert property (p_serial_pair) else $error("serial pair wrong");
   property p_select;
      $past(slave_select_mode_field) == 2'h0 |-> !sigAssigned[5];
   endproperty
   a_select: assert property (p_select) else $error("select placed in three-wire mode");
   property p_xbar_off;
      !$past(crossbarConfig.config2[6]) |-> sigAssigned == '0;
   endproperty
   a_xbar_off: assert property (p_xbar_off) else $error("signal placed while disabled");
   property p_skip;
      !$past(rst) |-> ((padOe ^ $past(gpioOe)) & $past(pin_skip_mask) & $past(pin_skip_mask, 2) & 16'hFFCF) == 16'h0000;
   endproperty
   a_skip: assert property (p_skip) else $error("skipped pin taken");
   property p_analog;
      ((pinRiseEvt | pinFallEvt) & ~(pinDigitalMode | $past(pinDigitalMode) | $past(pinDigitalMode, 2)
         | $past(pinDigitalMode, 3))) == 16'h0000;
   endproperty
   a_analog: assert property (p_analog) else $error("event on analog pin");
   property p_wake;
      eventWake == |(pinRiseEvt | pinFallEvt);
   endproperty
   a_wake: assert property (p_wake) else $error("wake mismatch");
   property p_hold;
      !$past(rst) && $stable(crossbarConfig) && $stable(pin_skip_mask) && $stable(slave_select_mode_field)
         |=> $stable(sigAssigned);
   endproperty
   a_hold: assert property (p_hold) else $error("map changed without cause");
endmodule : priority_crossbar_pin_assign_asserts
bind priority_crossbar_pin_assign priority_crossbar_pin_assign_asserts chk (.clk(clk), .rst(rst),
   .crossbarConfig(crossbarConfig), .pin_skip_mask(pin_skip_mask), .slave_select_mode_field(slave_select_mode_field),
   .pinDigitalMode(pinDigitalMode), .periphOut(periphOut), .sigAssigned(sigAssigned), .gpioOe(gpioOe),
   .padOut(padOut), .padOe(padOe), .pinRiseEvt(pinRiseEvt), .pinFallEvt(pinFallEvt), .eventWake(eventWake));

/* File: sim/tb.sv */
// self-checking bench for the priority crossbar pin assigner
`timescale 1ns/100ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin fail_count++; \
   $display("Error %s expected %h seen %h", n, e, g); end end
module tb;
   import xbar_pkg::*;
   logic           clk = 0;
   logic           rst = 1;
   xbar_cfg_type   cfg = '0;
   periph_out_type po = '0;
   logic [1:0]     ssm = 0;
   logic [15:0]    skip = 0, dig = 16'hFFFF, gOut = 0, gOe = 0, extOe = 0, extVal = 0;
   logic [31:0]    r = 32'hd75f_25bf;
   logic [16:0]    eAsg;
   logic [4:0]     own [16];
   logic [7:0]     nR, nF, nW;
   wire  [16:0]    pIn, asg;
   wire  [15:0]    gIn, padIn, pOut, pOe, rEvt, fEvt;
   wire            wake;
   int             fail_count = 0, check_count = 0, tn = 0;
   always #50 clk = ~clk;
   priority_crossbar_pin_assign uut (.clk(clk), .rst(rst), .crossbarConfig(cfg), .pin_skip_mask(skip),
      .slave_select_mode_field(ssm), .pinDigitalMode(dig), .periphOut(po), .periphIn(pIn), .sigAssigned(asg),
      .gpioOut(gOut), .gpioOe(gOe), .gpioIn(gIn), .padIn(padIn), .padOut(pOut), .padOe(pOe),
      .pinRiseEvt(rEvt), .pinFallEvt(fEvt), .eventWake(wake));
   pad_model pads (.padOut(pOut), .padOe(pOe), .extOe(extOe), .extVal(extVal), .padIn(padIn));
   function automatic logic [31:0] nx(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : nx
   // reference placement of all enabled signals
   function automatic void expect_map();
      logic [15:0] t;
      logic [16:0] en;
      int c;
      t = skip;
      eAsg = '0;
      c = cfg.config1[2:0] > 3 ? 3 : cfg.config1[2:0];
      en = {cfg.config1[5:3], 3'(7 >> (3 - c)), cfg.config0[5:3], {2{cfg.config0[2]}},
            cfg.config0[1] && ssm != 0, {3{cfg.config0[1]}}, 2'h0};
      foreach (own[p]) own[p] = 5'h1F;
      if (!cfg.config2[6]) return;
      if (cfg.config0[0]) begin
         eAsg[1:0] = 2'h3;
         own[4] = 5'h00;
         own[5] = 5'h01;
         t[5:4] = 2'h3;
      end
      for (int s = 2; s < 17; s++)
         for (int p = 0; p < 16; p++)
            if (en[s] && !t[p]) begin
               t[p] = 1'h1;
               own[p] = 5'(s);
               eAsg[s] = 1'h1;
               break;
            end
   endfunction : expect_map
   task automatic check_all();
      logic [15:0] eOe, eOut, lvl;
      logic [16:0] eIn;
      repeat (10) @(posedge clk);
      @(negedge clk);
      expect_map();
      eOe = gOe;
      eOut = gOut;
      foreach (own[p])
         if (own[p] != 5'h1F) begin
            eOe[p] = po.drive[own[p]];
            eOut[p] = po.value[own[p]];
         end
      lvl = (eOe & eOut) | (~eOe & (~extOe | extVal));
      eIn = '1;
      foreach (own[p])
         if (own[p] != 5'h1F)
            eIn[own[p]] = lvl[p];
      `CHK("sigAssigned", eAsg, asg)
      `CHK("padOe", eOe, pOe)
      `CHK("padOut", eOut, pOut)
      `CHK("periphIn", eIn, pIn)
      `CHK("gpioIn", lvl & dig, gIn)
      $display("test %0d done", tn++);
   endtask : check_all
   task automatic apply(input xbar_cfg_type c, input logic [15:0] s, input logic [1:0] m);
      @(posedge clk);
      r = nx(r);
      po <= {r, r[1:0]};
      r = nx(r);
      {gOut, gOe} <= r;
      r = nx(r);
      {extOe, extVal} <= r;
      cfg <= c;
      skip <= s;
      ssm <= m;
      check_all();
   endtask : apply
   task automatic finish_test();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : finish_test
   initial begin
      repeat (4) @(posedge clk);
      rst <= 0;
      apply(24'h40_0002, 16'h0000, 2'h0);
      apply(24'h40_0002, 16'h0001, 2'h1);
      apply(24'h00_3F3F, 16'h0000, 2'h3);
      apply(24'h40_3F3F, 16'hFFFF, 2'h2);
      apply(24'h40_3F3F, 16'h0043, 2'h1); // pins claimed outside the crossbar are skipped
      apply(24'h40_0004, 16'h0001, 2'h0);
      for (int i = 0; i < 40; i++) begin
         r = nx(r);
         apply({1'h0, |r[17:16], 8'h00, r[13:8], 2'h0, r[5:0]}, {8'h00, r[23:16] & r[31:24]}, r[7:6]);
      end
      // pin 9 toggles: routed to the counter input or skipped, digital or analog
      for (int k = 0; k < 4; k++) begin
         @(posedge clk);
         cfg <= 24'h40_0800;
         po <= '0;
         gOe <= 16'h0000;
         extOe <= 16'hFFFF;
         extVal <= 16'hFFFF;
         skip <= k[0] ? 16'h0200 : 16'h01FF;
         dig <= k[1] ? 16'hFDFF : 16'hFFFF;
         repeat (10) @(posedge clk);
         nR = 0;
         nF = 0;
         nW = 0;
         for (int i = 0; i < 30; i++) begin
            @(posedge clk);
            extVal[9] <= (i < 2 || i >= 15);
            @(negedge clk);
            nR += rEvt[9];
            nF += fEvt[9];
            nW += wake;
         end
         `CHK("rise count", k[1] ? 8'h00 : 8'h01, nR)
         `CHK("fall count", k[1] ? 8'h00 : 8'h01, nF)
         `CHK("wake count", k[1] ? 8'h00 : 8'h02, nW)
         `CHK("counter placed", 1'b1, asg[14])
         $display("event test %0d done", k);
      end
      finish_test();
   end
   initial begin
      repeat (3000) @(posedge clk);
      fail_count++;
      finish_test();
   end
endmodule : tb
